// file: boot_seq_pkg.sv
package boot_seq_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] status_off = 8'h04;
    localparam logic [7:0] irq_stat_off = 8'h08;
    localparam logic [7:0] irq_mask_off = 8'h0c;
    localparam logic [7:0] flash_cmd_off = 8'h10;
    localparam logic [7:0] readback_off = 8'h14;

    // Control register field positions.
    localparam int ctrl_monitor_en_bit = 0;
    localparam int ctrl_reference_on_bit = 1;
    localparam int ctrl_dual_boot_bit = 2;
    localparam int ctrl_crc_after_cfg_bit = 3;
    localparam int ctrl_checker_en_bit = 4;
    localparam int ctrl_pll_off_bit = 5;

    // Control reset value: monitoring and reference on, checker on.
    localparam logic [5:0] ctrl_reset = 6'h13;

    // Flash command codes written to the command register.
    localparam logic [2:0] cmd_none = 3'h0;
    localparam logic [2:0] cmd_program = 3'h1;
    localparam logic [2:0] cmd_erase = 3'h2;
    localparam logic [2:0] cmd_full_erase = 3'h3;
    localparam logic [2:0] cmd_set_security = 3'h4;
    localparam logic [2:0] cmd_set_otp = 3'h5;

    // Interrupt status bit positions.
    localparam int irq_user_bit = 0;
    localparam int irq_droop_bit = 1;
    localparam int irq_golden_bit = 2;
    localparam int irq_crc_err_bit = 3;
    localparam int irq_refused_bit = 4;
    localparam int irq_width = 5;

    // Flash download time and its cycle count at 200 MHz.
    localparam int flash_download_time_us = 10;
    localparam int clk_mhz = 200;
    localparam int download_cycles = flash_download_time_us * clk_mhz;

    // Soft-error checker clock divider ratio.
    localparam int checker_div = 8;

    // Sequencer states.
    typedef enum logic [5:0] {
        st_wait_supply = 6'h01,
        st_load_primary = 6'h02,
        st_load_golden = 6'h04,
        st_crc_check = 6'h08,
        st_user = 6'h10
    } seq_state_t;

endpackage

// file: power_on_boot_sequencer.sv
`timescale 1ns/1ps
module power_on_boot_sequencer
    import boot_seq_pkg::*;
#(
    parameter int download_cycles_p = download_cycles,
    parameter int io_width = 8,
    parameter bit regulated_core = 1'b1
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Supply monitor comparator outputs.
    input wire logic core_above_rising,
    input wire logic bank_above_rising,
    input wire logic ext_above_rising,
    input wire logic core_above_precise,
    input wire logic core_above_low_power,
    // Configuration load results.
    input wire logic primary_corrupt,
    input wire logic golden_corrupt,
    input wire logic crc_error,
    // User fabric.
    input wire logic [io_width-1:0] user_out,
    input wire logic [io_width-1:0] user_oe,
    input wire logic crc_request,
    output logic [io_width-1:0] io_out,
    output logic [io_width-1:0] io_oe,
    output logic user_mode,
    output logic device_reset,
    output logic load_from_internal,
    output logic load_from_spi,
    output logic checker_clk,
    // PLL power control.
    input wire logic pll_outputs_low,
    output logic pll_power_down,
    // Interrupt.
    output logic irq
);

    // Sequencer state and its next value.
    seq_state_t state_r, state_nxt;
    // Load and check timer.
    logic [31:0] timer_r;
    // Software control bits.
    logic [5:0] ctrl_r;
    // Security and one-time-programmable locks.
    logic secure_r;
    logic otp_r;
    // Sticky interrupt status and its mask.
    logic [irq_width-1:0] irq_stat_r;
    logic [irq_width-1:0] irq_mask_r;
    // Checker divider counter and its clock.
    logic [3:0] div_r;
    logic checker_clk_r;
    // Flag for a refused flash command or readback.
    logic refused;
    // Bus strobes.
    logic wr_en;
    logic rd_en;
    // Supplies good at power-up.
    logic supplies_up;
    // Droop event in user mode.
    logic droop;
    // Flash command field of the current write.
    logic [2:0] cmd;
    // Pins belong to the fabric in user mode and during a check that user logic asked for.
    logic io_to_user;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign cmd = pwdata[2:0];

    // Regulated parts also need the external supply up.
    assign supplies_up = core_above_rising && bank_above_rising
        && (!regulated_core || ext_above_rising);

    // Droop uses the precise threshold while the reference runs, else the low-power one.
    always_comb begin
        if (ctrl_r[ctrl_reference_on_bit]) begin
            droop = !core_above_precise;
        end else begin
            droop = !core_above_low_power;
        end
        if (!ctrl_r[ctrl_monitor_en_bit] || state_r != st_user) begin
            droop = 1'b0;
        end
    end

    // Next-state logic of the start-up sequence.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            st_wait_supply: begin
                // Every monitored supply has crossed its rising threshold.
                if (supplies_up) begin
                    state_nxt = st_load_primary;
                end
            end
            st_load_primary: begin
                // A corrupt primary falls back to the golden copy when allowed.
                if (primary_corrupt && ctrl_r[ctrl_dual_boot_bit]) begin
                    state_nxt = st_load_golden;
                end else if (timer_r >= 32'(download_cycles_p - 1)) begin
                    // Image fully loaded: check it first if asked, else run.
                    state_nxt = ctrl_r[ctrl_crc_after_cfg_bit] ? st_crc_check : st_user;
                end
            end
            st_load_golden: begin
                // A bad golden copy leaves nothing to run, so supplies are watched again.
                if (golden_corrupt) begin
                    state_nxt = st_wait_supply;
                end else if (timer_r >= 32'(download_cycles_p - 1)) begin
                    // Golden image fully loaded.
                    state_nxt = ctrl_r[ctrl_crc_after_cfg_bit] ? st_crc_check : st_user;
                end
            end
            st_crc_check: begin
                // The check runs for a fixed span, then user mode resumes.
                if (timer_r >= 32'(checker_div * 4 - 1)) begin
                    state_nxt = st_user;
                end
            end
            st_user: begin
                // Supply droop wins over a check request.
                if (droop) begin
                    state_nxt = st_wait_supply;
                end else if (crc_request && ctrl_r[ctrl_checker_en_bit]) begin
                    // User logic asks for a check while the checker runs.
                    state_nxt = st_crc_check;
                end
            end
            default: begin
                // An illegal code recovers to the supply wait.
                state_nxt = st_wait_supply;
            end
        endcase
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= st_wait_supply;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Timer restarts on every state change.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_r <= 32'h0;
        end else if (state_nxt != state_r) begin
            timer_r <= 32'h0;
        end else begin
            timer_r <= timer_r + 32'h1;
        end
    end

    // Image source selection: primary from internal flash, golden from SPI flash.
    assign load_from_internal = (state_r == st_load_primary);
    assign load_from_spi = (state_r == st_load_golden);

    // A user-requested check keeps user_mode high; a check right after loading does not.
    assign io_to_user = (state_nxt == st_user)
        || (state_nxt == st_crc_check && user_mode);

    // I/O ownership passes to user logic only in user mode or its own check.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_out <= '0;
            io_oe <= '0;
        end else if (io_to_user) begin
            io_out <= user_out;
            io_oe <= user_oe;
        end else begin
            io_out <= '0;
            io_oe <= '0;
        end
    end

    // User-mode flag and device reset output.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_mode <= 1'b0;
            device_reset <= 1'b1;
        end else if (droop) begin
            // Droop drops the flag and resets the device.
            user_mode <= 1'b0;
            device_reset <= 1'b1;
        end else if (state_nxt == st_user) begin
            // Entering user mode releases the device from reset.
            user_mode <= 1'b1;
            device_reset <= 1'b0;
        end else if (state_r == st_wait_supply) begin
            // While supplies are watched the device stays in reset.
            device_reset <= 1'b1;
        end
    end

    // Control register write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= ctrl_reset;
        end else if (wr_en && paddr == ctrl_off) begin
            ctrl_r <= pwdata[5:0];
        end
    end

    // Security and OTP locks; OTP blocks erase, only full erase clears security.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            secure_r <= 1'b0;
            otp_r <= 1'b0;
        end else if (wr_en && paddr == flash_cmd_off) begin
            if (cmd == cmd_set_security) begin
                // Each lock is set by its own command and by nothing else.
                secure_r <= 1'b1;
            end else if (cmd == cmd_set_otp) begin
                otp_r <= 1'b1;
            end else if (cmd == cmd_full_erase && !otp_r) begin
                // Under OTP the full erase is refused, so security sticks too.
                secure_r <= 1'b0;
            end
        end
    end

    // Refusal of locked readback or OTP-protected erase and program.
    always_comb begin
        refused = 1'b0;
        if (rd_en && paddr == readback_off && secure_r) begin
            refused = 1'b1;
        end else if (wr_en && paddr == flash_cmd_off && otp_r
            && (cmd == cmd_program || cmd == cmd_erase || cmd == cmd_full_erase)) begin
            refused = 1'b1;
        end
    end

    // Sticky status: events set, a read clears, and a set wins over the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= ((rd_en && paddr == irq_stat_off) ? '0 : irq_stat_r)
                | {refused,
                   crc_error && state_r == st_crc_check,
                   state_nxt == st_load_golden && state_r == st_load_primary,
                   droop,
                   state_nxt == st_user && state_r != st_user};
        end
    end

    // Interrupt mask register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_r <= '0;
        end else if (wr_en && paddr == irq_mask_off) begin
            irq_mask_r <= pwdata[irq_width-1:0];
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // Read data mux; locked readback returns zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == ctrl_off) begin
                prdata <= {26'h0, ctrl_r};
            end else if (paddr == status_off) begin
                prdata <= {24'h0, otp_r, secure_r, state_r};
            end else if (paddr == irq_stat_off) begin
                prdata <= {27'h0, irq_stat_r};
            end else if (paddr == irq_mask_off) begin
                prdata <= {27'h0, irq_mask_r};
            end else if (paddr == readback_off && !secure_r) begin
                prdata <= 32'(io_out);
            end else begin
                prdata <= 32'h0;
            end
        end
    end

    // Dedicated checker clock divider, stopped when the checker is off.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 4'h0;
            checker_clk_r <= 1'b0;
        end else if (!ctrl_r[ctrl_checker_en_bit]) begin
            // Checker off: divider and its clock are held low to save power.
            div_r <= 4'h0;
            checker_clk_r <= 1'b0;
        end else if (div_r == 4'(checker_div / 2 - 1)) begin
            // Half period reached: toggle the checker clock.
            div_r <= 4'h0;
            checker_clk_r <= !checker_clk_r;
        end else begin
            // Count towards the next toggle.
            div_r <= div_r + 4'h1;
        end
    end

    assign checker_clk = checker_clk_r;

    // PLL powers down only once all its outputs are low.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_power_down <= 1'b0;
        end else begin
            pll_power_down <= ctrl_r[ctrl_pll_off_bit] && pll_outputs_low;
        end
    end

endmodule // power_on_boot_sequencer

// file: boot_chk_sva.sv
`timescale 1ns/1ps
// Port checker; it shadows the control register from APB writes.
module boot_chk
    import boot_seq_pkg::*;
#(
    parameter int io_width = 8
) (
    // Clock, reset and bus.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    // Supplies and fabric.
    input wire logic core_above_rising,
    input wire logic bank_above_rising,
    input wire logic ext_above_rising,
    input wire logic core_above_precise,
    input wire logic core_above_low_power,
    input wire logic [io_width-1:0] user_oe,
    input wire logic [io_width-1:0] io_oe,
    // Sequencer outputs.
    input wire logic user_mode,
    input wire logic device_reset,
    input wire logic load_from_internal,
    input wire logic checker_clk,
    input wire logic pll_outputs_low,
    input wire logic pll_power_down
);
    logic [5:0] ctrl_r; // Shadow of the control register.
    logic sag; // Core is below the active falling threshold.
    // Follow control writes as the access phase takes them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= ctrl_reset;
        end else if (psel && penable && pwrite && paddr == ctrl_off) begin
            ctrl_r <= pwdata[5:0];
        end
    end
    assign sag = ctrl_r[1] ? !core_above_precise : !core_above_low_power;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    io_tristate_a: assert property (device_reset && $past(device_reset) |-> io_oe == '0)
        else $error("pins driven during load");
    io_handover_a: assert property (user_mode && $past(user_mode) |-> io_oe == $past(user_oe))
        else $error("pins not handed to fabric");
    user_reset_a: assert property (user_mode && $past(user_mode) |-> !device_reset)
        else $error("reset high in user mode");
    droop_reset_a: assert property (user_mode && ctrl_r[0] && sag |-> ##[1:3] !user_mode)
        else $error("droop did not reset");
    user_hold_a: assert property (user_mode && !(ctrl_r[0] && sag) |=> user_mode)
        else $error("user mode left without droop");
    load_start_a: assert property ($rose(load_from_internal) |->
        $past(core_above_rising && bank_above_rising && ext_above_rising))
        else $error("load started before supplies");
    pll_delay_a: assert property (pll_power_down == $past(ctrl_r[5] && pll_outputs_low))
        else $error("pll powered down early");
    clk_div_a: assert property (ctrl_r[4] && $changed(checker_clk) |=>
        (!ctrl_r[4] || $stable(checker_clk))[*3])
        else $error("checker clock ratio wrong");
    c_user: cover property ($rose(user_mode));
    c_droop: cover property ($fell(user_mode));
    c_load: cover property ($rose(load_from_internal));
endmodule // boot_chk

bind power_on_boot_sequencer boot_chk #(.io_width(io_width)) u_boot_chk (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .core_above_rising, .bank_above_rising,
    .ext_above_rising, .core_above_precise, .core_above_low_power, .user_oe, .io_oe,
    .user_mode, .device_reset, .load_from_internal, .checker_clk, .pll_outputs_low,
    .pll_power_down);

// file: supply_model.sv
`timescale 1ns/1ps
// Far side: supply comparators and the two configuration images.
module supply_model #(
    parameter int ramp_cycles = 6
) (
    // Clock, reset and bench controls.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic power_on,
    input wire logic [1:0] sag,
    input wire logic bad_primary,
    input wire logic load_from_internal,
    // Comparator levels and image status.
    output logic core_above_rising,
    output logic bank_above_rising,
    output logic ext_above_rising,
    output logic core_above_precise,
    output logic core_above_low_power,
    output logic primary_corrupt,
    output logic golden_corrupt
);
    int ramp_r; // Cycles since power was applied.
    // Supplies ramp up slowly after power is applied.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ramp_r <= 0;
        end else begin
            ramp_r <= !power_on ? 0 : (ramp_r < ramp_cycles) ? ramp_r + 1 : ramp_r;
        end
    end
    // Bank rises first; a sag of one trips the precise level, two trips both.
    assign bank_above_rising = ramp_r >= ramp_cycles / 2;
    assign core_above_rising = ramp_r >= ramp_cycles && sag == 2'd0;
    assign ext_above_rising = ramp_r >= ramp_cycles;
    assign core_above_precise = core_above_rising;
    assign core_above_low_power = ramp_r >= ramp_cycles && sag != 2'd2;
    // Primary is bad only while read; the golden copy is always present.
    assign primary_corrupt = bad_primary && load_from_internal;
    assign golden_corrupt = 1'b0;
endmodule // supply_model

// file: tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the boot sequencer.
module tb_top
    import boot_seq_pkg::*;
();
    logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, user_out, user_oe, io_out, io_oe;
    logic [31:0] pwdata, prdata, rd;
    logic core_above_rising, bank_above_rising, ext_above_rising, core_above_precise;
    logic core_above_low_power, primary_corrupt, golden_corrupt, crc_request, crc_error;
    logic user_mode, device_reset, load_from_internal, load_from_spi, checker_clk;
    logic pll_outputs_low, pll_power_down, irq, power_on, bad_primary;
    logic [1:0] sag;
    logic saw_spi = 1'b0; // Set once the golden image was fetched.
    logic bg_prog = 1'b0; // High while flash is programmed in the background.
    int fails = 0;
    int n_checks = 0;
    int exp_irq = 0; // Model of pending interrupt bits.
    always #2.5 pclk = ~pclk;
    power_on_boot_sequencer #(.download_cycles_p(8)) u_power_on_boot_sequencer (.pclk,
        .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .core_above_rising, .bank_above_rising, .ext_above_rising, .core_above_precise,
        .core_above_low_power, .primary_corrupt, .golden_corrupt, .crc_error, .user_out,
        .user_oe, .crc_request, .io_out, .io_oe, .user_mode, .device_reset,
        .load_from_internal, .load_from_spi, .checker_clk, .pll_outputs_low,
        .pll_power_down, .irq);
    supply_model u_supply_model (.pclk, .presetn, .power_on, .sag, .bad_primary,
        .load_from_internal, .core_above_rising, .bank_above_rising, .ext_above_rising,
        .core_above_precise, .core_above_low_power, .primary_corrupt, .golden_corrupt);
    // Random PLL output state, reported low while user logic holds the PLL in reset
    // for background programming, and the golden fetch record.
    always @(posedge pclk) begin
        pll_outputs_low <= bg_prog ? 1'b1 : 1'($urandom);
        if (load_from_spi === 1'b1) saw_spi <= 1'b1;
    end
    // Compare and count.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One APB transfer, held until pready at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Read a register and compare it.
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask
    // Bounded wait for a user mode level.
    task automatic wait_user(input logic lvl);
        for (int i = 0; i < 300 && user_mode !== lvl; i++) begin
            @(posedge pclk);
        end
    endtask
    // Print the counts and the verdict, then stop.
    task automatic complete_run();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Main sequence.
    initial begin
        void'($urandom(32'h2300eec6));
        {psel, penable, pwrite, paddr, pwdata, user_out, user_oe} = '0;
        {power_on, sag, bad_primary, crc_request, crc_error, presetn} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdc(ctrl_off, 32'h13);
        rdc(status_off, 32'h01);
        rdc(8'h20, 32'h0);
        apb(1'b1, irq_mask_off, 32'h1f);
        power_on <= 1'b1;
        wait_user(1'b1);
        check(user_mode, 1'b1);
        check(irq, 1'b1);
        exp_irq = 32'h01;
        rdc(irq_stat_off, exp_irq);
        rdc(status_off, 32'h10);
        check(irq, 1'b0);
        user_out <= 8'($urandom);
        user_oe <= 8'($urandom);
        apb(1'b1, flash_cmd_off, 32'(cmd_set_security));
        rdc(readback_off, 32'h0);
        apb(1'b1, flash_cmd_off, 32'(cmd_erase));
        rdc(status_off, 32'h50);
        apb(1'b1, flash_cmd_off, 32'(cmd_full_erase));
        rdc(readback_off, {24'h0, user_out});
        rdc(irq_stat_off, 32'h10);
        apb(1'b1, irq_mask_off, 32'h01);
        apb(1'b1, ctrl_off, 32'h32);
        sag <= 2'd2;
        repeat (6) @(posedge pclk);
        check(user_mode, 1'b1);
        bg_prog <= 1'b1;
        apb(1'b1, flash_cmd_off, 32'(cmd_program));
        check(pll_power_down, 1'b1);
        bg_prog <= 1'b0;
        sag <= 2'd0;
        apb(1'b1, ctrl_off, 32'h31);
        sag <= 2'd1;
        repeat (6) @(posedge pclk);
        check(user_mode, 1'b1);
        sag <= 2'd2;
        wait_user(1'b0);
        check(device_reset, 1'b1);
        check(irq, 1'b0);
        sag <= 2'd0;
        wait_user(1'b1);
        check(irq, 1'b1);
        exp_irq = 32'h03;
        rdc(irq_stat_off, exp_irq);
        apb(1'b1, ctrl_off, 32'h07);
        bad_primary <= 1'b1;
        sag <= 2'd2;
        wait_user(1'b0);
        sag <= 2'd0;
        wait_user(1'b1);
        check(saw_spi, 1'b1);
        exp_irq = 32'h07;
        rdc(irq_stat_off, exp_irq);
        // User-requested check: pins stay with the fabric, then user mode resumes.
        apb(1'b1, ctrl_off, 32'h1f);
        crc_request <= 1'b1;
        crc_error <= 1'b1;
        repeat (4) @(posedge pclk);
        crc_request <= 1'b0;
        rdc(status_off, 32'h08);
        check(io_oe, user_oe);
        crc_error <= 1'b0;
        repeat (40) @(posedge pclk);
        rdc(status_off, 32'h10);
        rdc(irq_stat_off, 32'h09);
        // Reboot with the check after loading: pins stay tristated through it.
        sag <= 2'd2;
        wait_user(1'b0);
        sag <= 2'd0;
        repeat (20) @(posedge pclk);
        rdc(status_off, 32'h08);
        check(io_oe, 32'h0);
        wait_user(1'b1);
        check(user_mode, 1'b1);
        rdc(irq_stat_off, 32'h07);
        apb(1'b1, flash_cmd_off, 32'(cmd_set_otp));
        apb(1'b1, flash_cmd_off, 32'(cmd_set_security));
        apb(1'b1, flash_cmd_off, 32'(cmd_program));
        apb(1'b1, flash_cmd_off, 32'(cmd_full_erase));
        rdc(status_off, 32'hd0);
        rdc(irq_stat_off, 32'h10);
        complete_run();
    end
    // Watchdog against a hang.
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        complete_run();
    end
endmodule // tb_top
